// File: ogc_top.v
// Purpose: offset/gain calibration datapath with register map checksum check
// Assumes: AHB-Lite single word transfers, one slave, data stream synchronous
// Notes: result latency two cycles, checksum sweep repeats continuously
`timescale 1ns/1ns
`include "ogc_regs.vh"
module ogc_top #(
  parameter [7:0] CRC_POLY = 8'h07,
  parameter [7:0] CRC_SEED = 8'hff
) (
  // clock and reset
  input wire clock_in,
  input wire srst_in,
  // ahb-lite slave
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output wire [31:0] hrdata_out,
  output wire hreadyout_out,
  output wire hresp_out,
  // conversion stream
  input wire sample_valid_in,
  input wire [23:0] sample_in,
  output reg result_valid_out,
  output reg [23:0] result_out,
  // status header and interrupt
  output wire [7:0] status_header_out,
  output wire irq_out
);
  // ********************************
  // register storage
  // ********************************
  reg [7:0] regs_q [0:15];
  reg [7:0] status_q;
  reg [31:0] rdata_q;
  reg wr_pend_q;
  reg [3:0] wr_idx_q;
  integer k;

  function [7:0] ogc_reset_val;
    input [3:0] idx;
    begin
      case (idx)
        `OGC_IDX_CONFIG: ogc_reset_val = `OGC_CFG_RESET;
        `OGC_IDX_OFS_HI: ogc_reset_val = `OGC_OFS_RESET;
        `OGC_IDX_OFS_MID: ogc_reset_val = `OGC_OFS_RESET;
        `OGC_IDX_OFS_LO: ogc_reset_val = `OGC_OFS_RESET;
        `OGC_IDX_GAIN_HI: ogc_reset_val = `OGC_GAIN_HI_RESET;
        `OGC_IDX_GAIN_MID: ogc_reset_val = `OGC_GAIN_LO_RESET;
        `OGC_IDX_GAIN_LO: ogc_reset_val = `OGC_GAIN_LO_RESET;
        `OGC_IDX_CHECKSUM: ogc_reset_val = `OGC_CHECKSUM_RESET;
        default: ogc_reset_val = 8'h00;
      endcase
    end
  endfunction

  // ********************************
  // ahb-lite slave
  // ********************************
  wire addr_phase = hsel_in && hready_in && htrans_in[1];
  wire [3:0] a_idx = haddr_in[5:2];
  wire [7:0] wbyte = hwdata_in[7:0];

  // ********************************
  // register write decode
  // ********************************
  function ogc_hit;
    input pend;
    input [3:0] idx;
    input [3:0] target;
    begin
      ogc_hit = pend && (idx == target);
    end
  endfunction

  wire wr_cfg = ogc_hit(wr_pend_q, wr_idx_q, `OGC_IDX_CONFIG);
  wire st_clr_wr = ogc_hit(wr_pend_q, wr_idx_q, `OGC_IDX_STATUS);
  wire wr_plain = wr_pend_q && !wr_cfg && !st_clr_wr;
  // reserved config bit keeps reading one
  wire [7:0] cfg_wbyte = (wbyte & ~`OGC_CFG_RO_MASK) | `OGC_CFG_RESET;
  wire [7:0] st_clr_mask = st_clr_wr ? wbyte : 8'h00;

  // ********************************
  // read data select
  // ********************************
  // a write still in its data phase is forwarded to a read of the same index
  reg [7:0] rd_byte_d;
  always @* begin
    rd_byte_d = regs_q[a_idx];
    if (haddr_in[31:6] != 26'h0) begin
      rd_byte_d = 8'h00;
    end else if (a_idx == `OGC_IDX_STATUS) begin
      rd_byte_d = status_q & ~st_clr_mask;
    end else if (ogc_hit(wr_pend_q, wr_idx_q, a_idx)) begin
      rd_byte_d = (a_idx == `OGC_IDX_CONFIG) ? cfg_wbyte : wbyte;
    end
  end

  always @(posedge clock_in) begin
    if (srst_in) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 4'h0;
      rdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= addr_phase && hwrite_in;
      if (addr_phase) begin
        wr_idx_q <= a_idx;
      end
      if (addr_phase && !hwrite_in) begin
        rdata_q <= {24'h000000, rd_byte_d};
      end
    end
  end

  assign hrdata_out = rdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  // ********************************
  // calibration words
  // ********************************
  wire [23:0] ofs_word = {regs_q[`OGC_IDX_OFS_HI], regs_q[`OGC_IDX_OFS_MID],
                          regs_q[`OGC_IDX_OFS_LO]};
  wire [23:0] gain_word = {regs_q[`OGC_IDX_GAIN_HI], regs_q[`OGC_IDX_GAIN_MID],
                           regs_q[`OGC_IDX_GAIN_LO]};
  wire check_en = regs_q[`OGC_IDX_CONFIG][`OGC_CFG_CHECK_EN];

  // ********************************
  // datapath: offset then gain
  // ********************************
  reg stage_valid_q;
  reg [24:0] diff_q;
  reg [23:0] res_d;
  reg ovr_d;
  wire [24:0] sample_ext = {sample_in[23], sample_in};
  wire [24:0] ofs_ext = {ofs_word[23], ofs_word};
  wire [24:0] gain_ext = {1'b0, gain_word};
  wire [24:0] diff_d = sample_ext - ofs_ext;
  wire signed [49:0] prod = $signed(diff_q) * $signed(gain_ext);
  wire signed [49:0] scaled = prod >>> `OGC_UNITY_SHIFT;
  wire pos_over = scaled > $signed({26'h0, `OGC_POS_MAX});
  wire neg_over = scaled < -$signed({26'h0, `OGC_NEG_MIN});

  always @* begin
    ovr_d = 1'b0;
    res_d = scaled[23:0];
    if (pos_over) begin
      res_d = `OGC_POS_MAX;
      ovr_d = 1'b1;
    end else if (neg_over) begin
      res_d = `OGC_NEG_MIN;
      ovr_d = 1'b1;
    end
  end

  always @(posedge clock_in) begin
    if (srst_in) begin
      stage_valid_q <= 1'b0;
      diff_q <= 25'h0;
      result_valid_out <= 1'b0;
      result_out <= 24'h000000;
    end else begin
      stage_valid_q <= sample_valid_in;
      if (sample_valid_in) begin
        diff_q <= diff_d;
      end
      result_valid_out <= stage_valid_q;
      if (stage_valid_q) begin
        result_out <= res_d;
      end
    end
  end

  // ********************************
  // checksum sweep over 0h-1h, 4h-eh
  // ********************************
  reg [3:0] sweep_q;
  wire [7:0] crc_val;
  wire sweep_start = (sweep_q == 4'h0);
  wire sweep_valid = (sweep_q <= 4'h1) || (sweep_q >= 4'h4 && sweep_q <= 4'he);
  wire sweep_end = (sweep_q == 4'hf);
  wire mismatch_ev = sweep_end && check_en &&
                     (crc_val != regs_q[`OGC_IDX_CHECKSUM]);

  always @(posedge clock_in) begin
    if (srst_in) begin
      sweep_q <= 4'h0;
    end else begin
      sweep_q <= sweep_q + 4'h1;
    end
  end

  ogc_checksum #(
    .POLY(CRC_POLY),
    .SEED(CRC_SEED)
  ) u_crc (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .start_in(sweep_start),
    .byte_valid_in(sweep_valid),
    .byte_in(regs_q[sweep_q]),
    .crc_out(crc_val)
  );

  // ********************************
  // register writes and status
  // ********************************
  wire ev_done = stage_valid_q;
  wire ev_over = stage_valid_q && ovr_d;
  wire [7:0] events = {5'h0, ev_done, ev_over, mismatch_ev};
  // set wins over write-one-to-clear
  wire [7:0] status_d = (status_q & ~st_clr_mask) | events;

  always @(posedge clock_in) begin
    if (srst_in) begin
      for (k = 0; k < 16; k = k + 1) begin
        regs_q[k] <= ogc_reset_val(k[3:0]);
      end
      status_q <= 8'h00;
    end else begin
      if (wr_cfg) begin
        regs_q[`OGC_IDX_CONFIG] <= cfg_wbyte;
      end else if (wr_plain) begin
        regs_q[wr_idx_q] <= wbyte;
      end
      status_q <= status_d;
    end
  end

  assign status_header_out = status_q;
  assign irq_out = |(status_q & regs_q[`OGC_IDX_MASK]);
endmodule

// File: ogc_regs.vh
// What this block does
// - Offset word is three bytes, high byte at 9h, low byte at Bh.
// - Offset is signed two's complement and subtracted from each result.
// - Offset subtraction happens before gain scaling.
// - Gain word is unsigned; 400000h means gain of one.
// - Result times gain over 400000h; gain high byte at lowest address.
// - Offset registers reset to 00h.
// - Gain registers reset to 40h, 00h, 00h.
// - Device checksum compared with stored; mismatch sets flag in header and status.
// - Comparison only while check enable is set.
// - Disabled: checksum register is plain scratchpad, reset 00h.
// - Check enable is bit 1 of register 8h, reset 0.
//
// Purpose: register offsets, fields and reset values of the calibration block
// Assumes: byte index times four is the AHB byte address
// Notes: registers 0h-7h other than status/mask are plain storage here
`ifndef OGC_REGS_VH
`define OGC_REGS_VH
`define OGC_IDX_CONFIG 4'h8
`define OGC_IDX_OFS_HI 4'h9
`define OGC_IDX_OFS_MID 4'ha
`define OGC_IDX_OFS_LO 4'hb
`define OGC_IDX_GAIN_HI 4'hc
`define OGC_IDX_GAIN_MID 4'hd
`define OGC_IDX_GAIN_LO 4'he
`define OGC_IDX_CHECKSUM 4'hf
`define OGC_IDX_STATUS 4'h2
`define OGC_IDX_MASK 4'h3
`define OGC_CFG_CHECK_EN 1
`define OGC_CFG_RESET 8'h08
`define OGC_CFG_RO_MASK 8'h08
`define OGC_ST_MISMATCH 0
`define OGC_ST_OVERRANGE 1
`define OGC_ST_DONE 2
`define OGC_OFS_RESET 8'h00
`define OGC_GAIN_HI_RESET 8'h40
`define OGC_GAIN_LO_RESET 8'h00
`define OGC_CHECKSUM_RESET 8'h00
`define OGC_UNITY_SHIFT 22
`define OGC_POS_MAX 24'h7fffff
`define OGC_NEG_MIN 24'h800000
`endif

// File: ogc_checksum.v
// Purpose: serial checksum over the covered register bytes
// Assumes: bytes presented one per cycle with byte_valid_in
// Notes: polynomial and seed are parameters
`timescale 1ns/1ns
module ogc_checksum #(
  parameter [7:0] POLY = 8'h07,
  parameter [7:0] SEED = 8'hff
) (
  // clock and reset
  input wire clock_in,
  input wire srst_in,
  // byte stream
  input wire start_in,
  input wire byte_valid_in,
  input wire [7:0] byte_in,
  // result
  output wire [7:0] crc_out
);
  reg [7:0] crc_q;

  function [7:0] ogc_crc_byte;
    input [7:0] crc;
    input [7:0] data;
    input [7:0] poly;
    integer i;
    reg [7:0] c;
    begin
      c = crc ^ data;
      for (i = 0; i < 8; i = i + 1) begin
        c = c[7] ? ((c << 1) ^ poly) : (c << 1);
      end
      ogc_crc_byte = c;
    end
  endfunction

  always @(posedge clock_in) begin
    if (srst_in) begin
      crc_q <= SEED;
    end else if (start_in) begin
      // first covered byte is folded in while the seed loads
      crc_q <= byte_valid_in ? ogc_crc_byte(SEED, byte_in, POLY) : SEED;
    end else if (byte_valid_in) begin
      crc_q <= ogc_crc_byte(crc_q, byte_in, POLY);
    end
  end

  assign crc_out = crc_q;
endmodule

// File: ogc_top_monitor.sv
// Purpose: assertion checker for ogc_top
// Assumes: one clock, synchronous reset
// Notes: attached to every ogc_top by bind
`timescale 1ns/1ns
module ogc_mon (
  // clock and reset
  input logic clock_in,
  input logic srst_in,
  // watched ports
  input logic sample_valid_in,
  input logic result_valid_out,
  input logic [23:0] result_out,
  input logic [31:0] hrdata_out,
  input logic hreadyout_out,
  input logic hresp_out,
  input logic [7:0] status_header_out,
  input logic irq_out
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  sequence s_res; ##2 result_valid_out; endsequence
  property p_lat; sample_valid_in |-> s_res; endproperty
  a_lat: assert property (p_lat) else $error("result late");
  property p_cause; result_valid_out |-> $past(sample_valid_in, 2); endproperty
  a_cause: assert property (p_cause) else $error("result without sample");
  property p_hold; $changed(result_out) |-> result_valid_out; endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_done; result_valid_out |-> ##[0:1] status_header_out[2]; endproperty
  a_done: assert property (p_done) else $error("done flag missing");
  property p_irq; irq_out |-> status_header_out != 8'h00; endproperty
  a_irq: assert property (p_irq) else $error("irq without status");
  property p_rst; $past(srst_in) |-> !result_valid_out && status_header_out == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("outputs after reset");
  property p_ok; hreadyout_out && !hresp_out; endproperty
  a_ok: assert property (p_ok) else $error("bus not ready");
  property p_rd; hrdata_out[31:8] == 24'h000000; endproperty
  a_rd: assert property (p_rd) else $error("read upper bits");
endmodule
bind ogc_top ogc_mon mon (
  .clock_in(clock_in),
  .srst_in(srst_in),
  .sample_valid_in(sample_valid_in),
  .result_valid_out(result_valid_out),
  .result_out(result_out),
  .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out),
  .status_header_out(status_header_out),
  .irq_out(irq_out)
);

// File: tb.sv
// Purpose: self-checking bench for ogc_top
// Assumes: zero wait bus, two cycle result latency
// Notes: expected results from a queue model
`timescale 1ns/1ns
module tb;
  logic clock_in = 0, srst_in = 1, hsel_in = 1, hwrite_in = 0, sample_valid_in = 0;
  logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, rd;
  logic [1:0] htrans_in = 0;
  logic [2:0] hsize_in = 3'h2;
  logic [23:0] sample_in = 0, result_out, ofs, gain;
  logic [7:0] status_header_out;
  logic hreadyout_out, hresp_out, result_valid_out, irq_out;
  wire hready_in = hreadyout_out;
  int n_fail = 0, total_checks = 0;
  logic [23:0] q[$];
  logic [15:0] rt[9] = '{16'h2008, 16'h2400, 16'h2800, 16'h2c00, 16'h3040,
    16'h3400, 16'h3800, 16'h3c00, 16'h4400};
  ogc_top dut (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hwdata_in(hwdata_in),
    .hready_in(hready_in),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .sample_valid_in(sample_valid_in),
    .sample_in(sample_in),
    .result_valid_out(result_valid_out),
    .result_out(result_out),
    .status_header_out(status_header_out),
    .irq_out(irq_out)
  );
  // ****
  // tasks
  // ****
  task chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task xfer(input bit w, input [7:0] a, input [7:0] d);
    htrans_in <= 2'h2;
    haddr_in <= {24'h0, a};
    hwrite_in <= w;
    @(posedge clock_in);
    while (!hreadyout_out) @(posedge clock_in);
    htrans_in <= 2'h0;
    hwdata_in <= {24'h0, d};
    @(posedge clock_in);
    while (!hreadyout_out) @(posedge clock_in);
    rd = hrdata_out;
  endtask
  function [23:0] cal(input [23:0] s);
    longint p;
    p = (($signed(longint'($signed(s))) - longint'($signed(ofs))) * longint'(gain)) >>> 22;
    cal = p > 8388607 ? 24'h7fffff : p < -8388608 ? 24'h800000 : p[23:0];
  endfunction
  task setcal(input [23:0] o, input [23:0] g);
    logic [47:0] v;
    v = {o, g};
    ofs = o;
    gain = g;
    for (int i = 0; i < 6; i++) xfer(1, 8'h24 + 8'(4 * i), v[47 - 8 * i -: 8]);
  endtask
  task burst(input int n, input bit rnd, input [23:0] s0);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      r = $urandom;
      sample_valid_in <= 1;
      sample_in <= rnd ? {{2{r[21]}}, r[21:0]} : s0;
      q.push_back(cal(rnd ? {{2{r[21]}}, r[21:0]} : s0));
      @(posedge clock_in);
    end
    sample_valid_in <= 0;
    repeat (3) @(posedge clock_in);
  endtask
  task chk_rst;
    foreach (rt[i]) begin
      xfer(0, rt[i][15:8], 8'h00);
      chk(rd, {24'h0, rt[i][7:0]});
    end
  endtask
  // crc-8, poly 07h, seed ffh, over indices 0,1,4..e; config holds enable and reserved bit
  function [7:0] crc_model;
    logic [7:0] c;
    logic [7:0] b[13];
    c = 8'hff;
    b = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, ofs[23:16], ofs[15:8], ofs[7:0],
      gain[23:16], gain[15:8], gain[7:0]};
    foreach (b[i]) begin
      c = c ^ b[i];
      repeat (8) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    crc_model = c;
  endfunction
  always @(posedge clock_in) if (!srst_in && result_valid_out) chk(result_out, q.pop_front());
  initial forever #10 clock_in = ~clock_in;
  initial begin
    #400000;
    n_fail++;
    wrap_up;
  end
  initial begin
    logic [31:0] r1, r2;
    void'($urandom(18994));
    repeat (3) @(posedge clock_in);
    srst_in <= 0;
    chk_rst;
    $display("test reset values done");
    xfer(1, 8'h3c, 8'h5a);
    xfer(0, 8'h3c, 8'h00);
    chk(rd, 32'h5a);
    repeat (40) @(posedge clock_in);
    xfer(0, 8'h08, 8'h00);
    chk(rd, 32'h0);
    $display("test scratchpad done");
    setcal(24'h800000, 24'h400000);
    burst(1, 0, 24'h7fffff);
    setcal(24'h000001, 24'h400000);
    burst(1, 0, 24'h800000);
    for (int k = 0; k < 4; k++) begin
      r1 = $urandom;
      r2 = $urandom;
      setcal({{4{r1[19]}}, r1[19:0]}, {1'b0, r2[22:0]});
      burst(20, 1, 24'h0);
    end
    $display("test calibration done");
    xfer(0, 8'h08, 8'h00);
    chk(rd, 32'h06);
    xfer(1, 8'h0c, 8'h04);
    @(posedge clock_in);
    chk(irq_out, 1'b1);
    xfer(1, 8'h08, 8'h06);
    xfer(0, 8'h08, 8'h00);
    chk({rd[7:0], irq_out}, 9'h0);
    $display("test status done");
    xfer(1, 8'h20, 8'h02);
    xfer(0, 8'h20, 8'h00);
    chk(rd, 32'h0a);
    xfer(1, 8'h3c, crc_model());
    xfer(1, 8'h08, 8'h01);
    repeat (40) @(posedge clock_in);
    xfer(0, 8'h08, 8'h00);
    chk(rd[0], 1'b0);
    xfer(1, 8'h3c, crc_model() ^ 8'h01);
    repeat (40) @(posedge clock_in);
    xfer(0, 8'h08, 8'h00);
    chk(rd[0], 1'b1);
    chk(status_header_out[0], 1'b1);
    xfer(1, 8'h20, 8'h00);
    xfer(1, 8'h08, 8'h01);
    repeat (40) @(posedge clock_in);
    xfer(0, 8'h08, 8'h00);
    chk(rd[0], 1'b0);
    $display("test checksum done");
    srst_in <= 1;
    repeat (3) @(posedge clock_in);
    srst_in <= 0;
    chk_rst;
    $display("test second reset done");
    wrap_up;
  end
endmodule
